// >>> pmic_reg_pkg.sv
package pmic_reg_pkg;
   // ==========================================================
   // Register offsets.
   // ==========================================================
   localparam logic [7:0] ADDR_TEMP = 8'h00;
   localparam logic [7:0] ADDR_ENABLE = 8'h01;
   localparam logic [7:0] ADDR_POS_ADJ = 8'h02;
   localparam logic [7:0] ADDR_NEG_ADJ = 8'h03;
   localparam logic [7:0] ADDR_BIAS = 8'h04;
   localparam logic [7:0] ADDR_MASK1 = 8'h05;
   localparam logic [7:0] ADDR_MASK2 = 8'h06;
   localparam logic [7:0] ADDR_FLAGS1 = 8'h07;
   localparam logic [7:0] ADDR_FLAGS2 = 8'h08;
   localparam logic [7:0] ADDR_ORDER = 8'h09;
   localparam logic [7:0] ADDR_DLY_A = 8'h0a;
   localparam logic [7:0] ADDR_DLY_B = 8'h0b;
   localparam logic [7:0] ADDR_TCFG = 8'h0c;
   localparam logic [7:0] ADDR_HOT = 8'h0d;
   localparam logic [7:0] ADDR_COOL = 8'h0e;
   localparam logic [7:0] ADDR_PGOOD = 8'h0f;
   localparam logic [7:0] ADDR_REV = 8'h10;
   localparam logic [7:0] ADDR_LOCK = 8'h11;
   // ==========================================================
   // Reset values and writable-bit masks.
   // ==========================================================
   localparam logic [7:0] RST_ENABLE = 8'h1f;
   localparam logic [7:0] RST_POS_ADJ = 8'h23;
   localparam logic [7:0] RST_NEG_ADJ = 8'ha3;
   localparam logic [7:0] RST_BIAS = 8'h74;
   localparam logic [7:0] RST_MASK1 = 8'h74;
   localparam logic [7:0] RST_MASK2 = 8'hfb;
   localparam logic [7:0] RST_ORDER = 8'he4;
   localparam logic [7:0] RST_DLY = 8'h22;
   localparam logic [7:0] RST_TCFG = 8'h20;
   localparam logic [7:0] RST_HOT = 8'h32;
   localparam logic [7:0] RST_COOL = 8'h2d;
   localparam logic [7:0] WM_ENABLE = 8'h3f;
   localparam logic [7:0] WM_POS_ADJ = 8'h77;
   localparam logic [7:0] WM_NEG_ADJ = 8'hf7;
   localparam logic [7:0] WM_MASK1 = 8'h7c;
   localparam logic [7:0] WM_MASK2 = 8'hfb;
   localparam logic [7:0] WM_TCFG = 8'h9c;
   localparam logic [7:0] WM_LOCK = 8'h01;
   localparam logic [7:0] PG_MASK = 8'hfa;
   localparam logic [7:0] UV_BASE_BITS = 8'ha0;
   localparam logic [7:0] UV_ALL_BITS = 8'hfa;
   // ==========================================================
   // Field positions.
   // ==========================================================
   localparam int EN_ACTIVE_BIT = 7;
   localparam int EN_STANDBY_BIT = 6;
   localparam int EN_SWITCH_BIT = 5;
   localparam int EN_BIAS_BIT = 4;
   localparam int EN_POS_GATE_BIT = 3;
   localparam int EN_POS_SRC_BIT = 2;
   localparam int EN_NEG_GATE_BIT = 1;
   localparam int EN_NEG_SRC_BIT = 0;
   localparam int TRIM_LSB = 4;
   localparam int LEVEL_LSB = 0;
   localparam int FIELD_W = 3;
   localparam int BIAS_SEL_BIT = 7;
   localparam int READ_THERM_BIT = 7;
   localparam int CONV_END_BIT = 5;
   localparam int LOCK_BIT = 0;
   localparam int F1_TSD_BIT = 6;
   localparam int F1_WARN_BIT = 5;
   localparam int F1_HOT_BIT = 4;
   localparam int F1_ESC_BIT = 3;
   localparam int F1_UVLO_BIT = 2;
   localparam int F2_EOC_BIT = 0;
   localparam logic [2:0] ALL_STROBES = 3'h4;
   // ==========================================================
   // Temperature limits and timing.
   // ==========================================================
   localparam logic [7:0] TEMP_LOW = 8'hf6;
   localparam logic [7:0] TEMP_HIGH = 8'h55;
   localparam logic signed [9:0] TEMP_LOW_S = -10'sd10;
   localparam logic signed [9:0] TEMP_HIGH_S = 10'sd85;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MS_IN_PS = 1000000000;
   localparam int MS_CYCLES_DOC = MS_IN_PS / CLK_PERIOD_PS;
   localparam logic [3:0] UV_LIMIT_MS = 4'h5;
   localparam logic [3:0] UV_BASE_LIMIT_MS = 4'ha;
   // ==========================================================
   // Carrier types.
   // ==========================================================
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
   typedef struct packed {
      logic valid;
      logic signed [9:0] degrees;
   } temp_sample_type;
   typedef struct packed {
      logic systemSwitch;
      logic biasBuffer;
      logic posGate;
      logic posSource;
      logic negGate;
      logic negSource;
      logic boostOn;
      logic inverterOn;
   } rail_ctl_type;
   typedef struct packed {
      logic [2:0] posGateTrim;
      logic [2:0] posSourceOffset;
      logic [2:0] negGateTrim;
      logic [2:0] negSourceLevel;
      logic biasSourceSelect;
      logic [7:0] biasLevelCode;
   } trim_type;
   typedef enum logic [3:0] {
      ST_STANDBY = 4'h1,
      ST_UP = 4'h2,
      ST_ACTIVE = 4'h4,
      ST_DOWN = 4'h8
   } seq_state_type;
endpackage

// >>> epd_pmic_control_registers.sv
module epd_pmic_control_registers #(
   parameter int MS_CYCLES = pmic_reg_pkg::MS_CYCLES_DOC, // Clock cycles per millisecond.
   parameter logic [7:0] REVISION_CODE = 8'h5a // Arbitrary neutral revision value.
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire pmic_reg_pkg::reg_req_type regReq,
   output logic [7:0] rdData,
   output logic rdValid,
   input wire pmic_reg_pkg::temp_sample_type tempSample,
   input wire logic [4:0] railPowerPins,
   input wire logic [7:0] powerGoodIn,
   input wire logic thermalShutdownIn,
   input wire logic thermalWarnIn,
   input wire logic inputLowIn,
   output pmic_reg_pkg::rail_ctl_type railCtl,
   output pmic_reg_pkg::trim_type trims,
   output logic convStart,
   output logic eventPending,
   output logic activeMode
);
   import pmic_reg_pkg::*;

   // ==========================================================
   // State record.
   // ==========================================================
   // Everything the block remembers lives in one packed record.
   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] posAdj;
      logic [7:0] negAdj;
      logic [7:0] bias;
      logic [7:0] mask1;
      logic [7:0] mask2;
      logic [7:0] order;
      logic [7:0] dlyA;
      logic [7:0] dlyB;
      logic [7:0] tcfg;
      logic [7:0] hotLim;
      logic [7:0] coolLim;
      logic [7:0] lock;
      logic [7:0] temp;
      logic [7:0] flags1;
      logic [7:0] flags2;
      logic [7:0] pgood;
      seq_state_type seq;
      logic [2:0] step;
      logic [17:0] presc;
      logic [3:0] msCnt;
      logic [7:0][3:0] uvCnt;
      logic hotSeen;
      logic [7:0] rdData;
      logic rdValid;
      logic pending;
      logic active; // Registered copy of the active-state decode.
      rail_ctl_type rails;
      trim_type trims;
   } state_type;

   // Builds the reset image from constants only.
   function automatic state_type resetImage();
      state_type r;
      r = '0;
      r.enable = RST_ENABLE;
      r.posAdj = RST_POS_ADJ;
      r.negAdj = RST_NEG_ADJ;
      r.bias = RST_BIAS;
      r.mask1 = RST_MASK1;
      r.mask2 = RST_MASK2;
      r.order = RST_ORDER;
      r.dlyA = RST_DLY;
      r.dlyB = RST_DLY;
      r.tcfg = RST_TCFG;
      r.hotLim = RST_HOT;
      r.coolLim = RST_COOL;
      r.seq = ST_STANDBY;
      r.trims.posGateTrim = RST_POS_ADJ[TRIM_LSB +: FIELD_W];
      r.trims.posSourceOffset = RST_POS_ADJ[LEVEL_LSB +: FIELD_W];
      r.trims.negGateTrim = RST_NEG_ADJ[TRIM_LSB +: FIELD_W];
      r.trims.negSourceLevel = RST_NEG_ADJ[LEVEL_LSB +: FIELD_W];
      r.trims.biasSourceSelect = RST_NEG_ADJ[BIAS_SEL_BIT];
      r.trims.biasLevelCode = RST_BIAS;
      return r;
   endfunction

   localparam state_type STATE_RST = resetImage();

   // Picks one of the four 4-bit millisecond delays.
   function automatic logic [3:0] delayOf(input logic [1:0] idx, input logic [7:0] a,
                                          input logic [7:0] b);
      logic [15:0] all;
      all = {b, a};
      return all[idx*4 +: 4];
   endfunction

   state_type s_q; // Registered state.
   state_type s_d; // Next state.
   logic standbyReq; // Standby request written this cycle.
   logic activeReq; // Active request written this cycle.
   logic msTick; // One-cycle pulse each millisecond.
   logic [7:0] rdAddr; // Read pointer after the lock is applied.
   logic [7:0] tempSat; // Saturated reading.
   logic [7:0] uvEn; // Rails whose undervoltage watch is armed.
   logic [3:0] uvLimit; // Per-rail timeout in milliseconds.
   logic [1:0] dlyIdx; // Active delay slot.
   logic stepDue; // Current sequencer delay elapsed.

   // ==========================================================
   // Next-state logic.
   // ==========================================================
   // One process computes every field so that flags, sequencer and bus see one view.
   always_comb begin
      s_d = s_q;
      standbyReq = 1'b0;
      activeReq = 1'b0;
      uvLimit = UV_LIMIT_MS;
      s_d.rdValid = 1'b0;
      msTick = (s_q.presc == 18'(MS_CYCLES - 1));
      s_d.presc = msTick ? 18'h0 : s_q.presc + 18'h1;
      // The lock steers every read to the temperature byte; writes are untouched.
      rdAddr = s_q.lock[LOCK_BIT] ? ADDR_TEMP : regReq.addr;

      // Temperature capture, clamped to the documented range.
      if (tempSample.degrees < TEMP_LOW_S) begin
         tempSat = TEMP_LOW;
      end else if (tempSample.degrees > TEMP_HIGH_S) begin
         tempSat = TEMP_HIGH;
      end else begin
         tempSat = tempSample.degrees[7:0];
      end
      if (tempSample.valid) begin
         s_d.temp = tempSat;
         s_d.tcfg[CONV_END_BIT] = 1'b1;
         s_d.tcfg[READ_THERM_BIT] = 1'b0;
      end

      // Register writes; read-only and unused bits are masked away.
      if (regReq.wrEn) begin
         case (regReq.addr)
            ADDR_ENABLE: begin
               s_d.enable = regReq.wdata & WM_ENABLE;
               standbyReq = regReq.wdata[EN_STANDBY_BIT];
               activeReq = regReq.wdata[EN_ACTIVE_BIT];
            end
            ADDR_POS_ADJ: s_d.posAdj = regReq.wdata & WM_POS_ADJ;
            ADDR_NEG_ADJ: s_d.negAdj = regReq.wdata & WM_NEG_ADJ;
            ADDR_BIAS: s_d.bias = regReq.wdata;
            ADDR_MASK1: s_d.mask1 = regReq.wdata & WM_MASK1;
            ADDR_MASK2: s_d.mask2 = regReq.wdata & WM_MASK2;
            ADDR_ORDER: s_d.order = regReq.wdata;
            ADDR_DLY_A: s_d.dlyA = regReq.wdata;
            ADDR_DLY_B: s_d.dlyB = regReq.wdata;
            ADDR_TCFG: begin
               // A new start request supersedes the completion seen this cycle.
               s_d.tcfg = (s_d.tcfg & ~WM_TCFG) | (regReq.wdata & WM_TCFG);
               if (regReq.wdata[READ_THERM_BIT]) begin
                  s_d.tcfg[CONV_END_BIT] = 1'b0;
               end
            end
            ADDR_HOT: s_d.hotLim = regReq.wdata;
            ADDR_COOL: s_d.coolLim = regReq.wdata;
            ADDR_LOCK: s_d.lock = regReq.wdata & WM_LOCK;
            default: begin
               // Read-only and unmapped offsets ignore writes.
               s_d.lock = s_d.lock;
            end
         endcase
      end

      // Sticky flags: a read of the flag register clears it, but a set in the
      // same cycle survives because the set terms are ORed in afterwards.
      if (regReq.rdEn && rdAddr == ADDR_FLAGS1) begin
         s_d.flags1 = 8'h00;
      end
      if (regReq.rdEn && rdAddr == ADDR_FLAGS2) begin
         s_d.flags2 = 8'h00;
      end
      s_d.flags1[F1_TSD_BIT] = s_d.flags1[F1_TSD_BIT] | thermalShutdownIn;
      s_d.flags1[F1_WARN_BIT] = s_d.flags1[F1_WARN_BIT] | thermalWarnIn;
      s_d.flags1[F1_UVLO_BIT] = s_d.flags1[F1_UVLO_BIT] | inputLowIn;
      s_d.flags2[F2_EOC_BIT] = s_d.flags2[F2_EOC_BIT] | tempSample.valid;
      // Thermistor hot and hot-escape events, with the cool limit as hysteresis.
      if (tempSample.valid) begin
         if (!s_q.hotSeen && $signed(tempSat) >= $signed(s_q.hotLim)) begin
            s_d.hotSeen = 1'b1;
            s_d.flags1[F1_HOT_BIT] = 1'b1;
         end else if (s_q.hotSeen && $signed(tempSat) < $signed(s_q.coolLim)) begin
            s_d.hotSeen = 1'b0;
            s_d.flags1[F1_ESC_BIT] = 1'b1;
         end
      end

      // Power sequencer: step counts how many strobes are asserted.
      if (s_q.seq == ST_DOWN) begin
         // Going down, strobe 4 waits on delay 0, then 3, 2, 1 on their own slots.
         dlyIdx = (s_q.step == ALL_STROBES) ? 2'h0 : s_q.step[1:0];
      end else begin
         dlyIdx = s_q.step[1:0];
      end
      stepDue = (s_q.msCnt == delayOf(dlyIdx, s_q.dlyA, s_q.dlyB));
      if (msTick) begin
         s_d.msCnt = s_q.msCnt + 4'h1;
      end
      case (s_q.seq)
         ST_STANDBY: begin
            if (activeReq && !standbyReq) begin
               s_d.seq = ST_UP;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end
         end
         ST_UP: begin
            if (standbyReq) begin
               // Standby has priority over any active request.
               s_d.seq = ST_DOWN;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end else if (s_q.step == ALL_STROBES) begin
               s_d.seq = ST_ACTIVE;
            end else if (stepDue) begin
               s_d.step = s_q.step + 3'h1;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end
         end
         ST_ACTIVE: begin
            if (standbyReq) begin
               s_d.seq = ST_DOWN;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end
         end
         ST_DOWN: begin
            if (activeReq && !standbyReq) begin
               s_d.seq = ST_UP;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end else if (s_q.step == 3'h0) begin
               s_d.seq = ST_STANDBY;
            end else if (stepDue) begin
               s_d.step = s_q.step - 3'h1;
               s_d.msCnt = 4'h0;
               s_d.presc = 18'h0;
            end
         end
         default: begin
            s_d.seq = ST_STANDBY;
            s_d.step = 3'h0;
         end
      endcase
      // The mode output is decoded ahead of the register so the pin comes from a flop.
      s_d.active = (s_d.seq == ST_ACTIVE);

      // Gate and source enables: register bit AND pin AND strobe already reached.
      s_d.rails.systemSwitch = s_q.enable[EN_SWITCH_BIT];
      s_d.rails.biasBuffer = s_q.enable[EN_BIAS_BIT] & railPowerPins[EN_BIAS_BIT];
      s_d.rails.posGate = s_q.enable[EN_POS_GATE_BIT] & railPowerPins[EN_POS_GATE_BIT]
                          & ({1'b0, s_q.order[7:6]} < s_q.step);
      s_d.rails.negGate = s_q.enable[EN_NEG_GATE_BIT] & railPowerPins[EN_NEG_GATE_BIT]
                          & ({1'b0, s_q.order[3:2]} < s_q.step);
      s_d.rails.negSource = s_q.enable[EN_NEG_SRC_BIT] & railPowerPins[EN_NEG_SRC_BIT]
                            & ({1'b0, s_q.order[1:0]} < s_q.step);
      // The positive source is held off while the negative source is off.
      s_d.rails.posSource = s_q.enable[EN_POS_SRC_BIT] & railPowerPins[EN_POS_SRC_BIT]
                            & ({1'b0, s_q.order[5:4]} < s_q.step)
                            & s_d.rails.negSource;
      s_d.rails.boostOn = (s_q.seq != ST_STANDBY);
      s_d.rails.inverterOn = (s_q.seq != ST_STANDBY);

      // Analog settings; the positive source offset comes from posAdj bits 2:0 alone.
      s_d.trims.posGateTrim = s_q.posAdj[TRIM_LSB +: FIELD_W];
      s_d.trims.posSourceOffset = s_q.posAdj[LEVEL_LSB +: FIELD_W];
      s_d.trims.negGateTrim = s_q.negAdj[TRIM_LSB +: FIELD_W];
      s_d.trims.negSourceLevel = s_q.negAdj[LEVEL_LSB +: FIELD_W];
      s_d.trims.biasSourceSelect = s_q.negAdj[BIAS_SEL_BIT];
      s_d.trims.biasLevelCode = s_q.bias;

      // Undervoltage watch: counts whole milliseconds without power good.
      // One extra tick is counted because the first tick may come early.
      s_d.pgood = powerGoodIn & PG_MASK;
      uvEn = {s_q.rails.boostOn, s_q.rails.posGate, s_q.rails.inverterOn,
              s_q.rails.posSource, s_q.rails.negGate, 1'b0, s_q.rails.negSource, 1'b0};
      for (int i = 0; i < 8; i++) begin
         uvLimit = UV_BASE_BITS[i] ? UV_BASE_LIMIT_MS : UV_LIMIT_MS;
         if (!UV_ALL_BITS[i] || !uvEn[i] || s_q.pgood[i]) begin
            s_d.uvCnt[i] = 4'h0;
         end else if (s_q.uvCnt[i] > uvLimit) begin
            s_d.flags2[i] = 1'b1;
         end else if (msTick) begin
            s_d.uvCnt[i] = s_q.uvCnt[i] + 4'h1;
         end
      end

      s_d.pending = |((s_q.flags1 & s_q.mask1) | (s_q.flags2 & s_q.mask2));

      // Read port answers one cycle after the request.
      if (regReq.rdEn) begin
         s_d.rdValid = 1'b1;
         case (rdAddr)
            ADDR_TEMP: s_d.rdData = s_q.temp;
            ADDR_ENABLE: s_d.rdData = s_q.enable;
            ADDR_POS_ADJ: s_d.rdData = s_q.posAdj;
            ADDR_NEG_ADJ: s_d.rdData = s_q.negAdj;
            ADDR_BIAS: s_d.rdData = s_q.bias;
            ADDR_MASK1: s_d.rdData = s_q.mask1;
            ADDR_MASK2: s_d.rdData = s_q.mask2;
            ADDR_FLAGS1: s_d.rdData = s_q.flags1;
            ADDR_FLAGS2: s_d.rdData = s_q.flags2;
            ADDR_ORDER: s_d.rdData = s_q.order;
            ADDR_DLY_A: s_d.rdData = s_q.dlyA;
            ADDR_DLY_B: s_d.rdData = s_q.dlyB;
            ADDR_TCFG: s_d.rdData = s_q.tcfg;
            ADDR_HOT: s_d.rdData = s_q.hotLim;
            ADDR_COOL: s_d.rdData = s_q.coolLim;
            ADDR_PGOOD: s_d.rdData = s_q.pgood;
            ADDR_REV: s_d.rdData = REVISION_CODE;
            ADDR_LOCK: s_d.rdData = s_q.lock;
            default: s_d.rdData = 8'h00;
         endcase
      end
   end

   // ==========================================================
   // State register.
   // ==========================================================
   // Reset loads every writable field with its default.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdData = s_q.rdData;
   assign rdValid = s_q.rdValid;
   assign railCtl = s_q.rails;
   assign trims = s_q.trims;
   assign convStart = s_q.tcfg[READ_THERM_BIT];
   assign eventPending = s_q.pending;
   assign activeMode = s_q.active;

   // ==========================================================
   // Checks.
   // ==========================================================
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_temp_low_clamp: assert property (tempSample.valid && tempSample.degrees < TEMP_LOW_S
      |=> s_q.temp == TEMP_LOW) else $error("Low reading not clamped.");
   a_temp_high_clamp: assert property (tempSample.valid && tempSample.degrees > TEMP_HIGH_S
      |=> s_q.temp == TEMP_HIGH) else $error("High reading not clamped.");
   a_active_starts_up: assert property (s_q.seq == ST_STANDBY && regReq.wrEn
      && regReq.addr == ADDR_ENABLE && regReq.wdata[EN_ACTIVE_BIT]
      && !regReq.wdata[EN_STANDBY_BIT] |=> s_q.seq == ST_UP && s_q.enable[EN_ACTIVE_BIT] == 1'b0)
      else $error("Active request not taken.");
   a_standby_wins: assert property ((s_q.seq == ST_ACTIVE || s_q.seq == ST_UP) && regReq.wrEn
      && regReq.addr == ADDR_ENABLE && regReq.wdata[EN_STANDBY_BIT] |=> s_q.seq == ST_DOWN)
      else $error("Standby request lost.");
   a_switch_follows: assert property (regReq.wrEn && regReq.addr == ADDR_ENABLE
      |-> ##2 railCtl.systemSwitch == $past(regReq.wdata[EN_SWITCH_BIT], 2))
      else $error("System switch does not follow its bit.");
   a_rail_and_pin: assert property (railCtl.posGate |-> $past(railPowerPins[EN_POS_GATE_BIT])
      && $past(s_q.enable[EN_POS_GATE_BIT])) else $error("Gate pump on without pin.");
   a_pos_after_neg: assert property (railCtl.posSource |-> railCtl.negSource)
      else $error("Positive source on without negative.");
   a_down_reverses: assert property (s_q.seq == ST_DOWN && $past(s_q.seq) == ST_DOWN
      |-> s_q.step <= $past(s_q.step)) else $error("Strobe rose while powering down.");
   a_locked_read: assert property (regReq.rdEn && s_q.lock[LOCK_BIT]
      |=> rdValid && rdData == $past(s_q.temp)) else $error("Locked read not temperature.");
   a_pos_trim_write: assert property (regReq.wrEn && regReq.addr == ADDR_POS_ADJ
      |-> ##2 trims.posGateTrim == $past(regReq.wdata[6:4], 2))
      else $error("Gate trim not applied.");

   c_reach_active: cover property (s_q.seq == ST_UP ##1 s_q.seq == ST_ACTIVE);
   c_back_standby: cover property (s_q.seq == ST_DOWN ##1 s_q.seq == ST_STANDBY);
   c_uv_flag: cover property ($rose(s_q.flags2[EN_POS_GATE_BIT + 3]));
   c_locked_read: cover property (regReq.rdEn && s_q.lock[LOCK_BIT]);
endmodule

// >>> rail_model.sv
module rail_model (
   input wire pmic_reg_pkg::rail_ctl_type railCtl,
   output logic [7:0] powerGoodIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Every rail reports good at once except the negative source, which never does,
   // so its undervoltage watch is the only one that can time out.
   assign powerGoodIn = {railCtl.boostOn, railCtl.posGate, railCtl.inverterOn,
      railCtl.posSource, railCtl.negGate, 1'b0, 1'b0, 1'b0};
endmodule

// >>> testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmic_reg_pkg::*;
   // ==========
   // One ms is cut to eight cycles to keep the sequencer runs short.
   logic mclk, rst_n, rdValid, convStart, eventPending, activeMode;
   logic [7:0] rdData, powerGoodIn;
   logic [4:0] railPowerPins;
   logic [2:0] evIn; // Thermal shutdown, thermal warning and input-low events.
   logic [7:0] posView, negView; // Trim outputs packed in register layout.
   reg_req_type regReq;
   temp_sample_type tempSample;
   rail_ctl_type railCtl;
   trim_type trims;
   int nMismatch, totalChecks;
   localparam logic [7:0] ADR [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
   localparam logic [7:0] DEF [15] = '{8'h1f, 8'h23, 8'ha3, 8'h74, 8'h74, 8'hfb,
      8'he4, 8'h22, 8'h22, 8'h20, 8'h32, 8'h2d, 8'h00, 8'h5a, 8'h00};
   epd_pmic_control_registers #(.MS_CYCLES(8)) i_dut (.mclk(mclk), .rst_n(rst_n),
      .regReq(regReq), .rdData(rdData), .rdValid(rdValid), .tempSample(tempSample),
      .railPowerPins(railPowerPins), .powerGoodIn(powerGoodIn),
      .thermalShutdownIn(evIn[2]), .thermalWarnIn(evIn[1]), .inputLowIn(evIn[0]),
      .railCtl(railCtl), .trims(trims), .convStart(convStart),
      .eventPending(eventPending), .activeMode(activeMode));
   rail_model i_rails (.railCtl(railCtl), .powerGoodIn(powerGoodIn));
   assign posView = {1'b0, trims.posGateTrim, 1'b0, trims.posSourceOffset};
   assign negView = {trims.biasSourceSelect, trims.negGateTrim, 1'b0, trims.negSourceLevel};
   task automatic cmp(string nm, logic [7:0] e, logic [7:0] s);
      totalChecks++;
      if (s !== e) begin
         nMismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask
   // Each access ends one idle cycle later, so a strobe never rises and falls at once.
   task automatic wr(logic [7:0] a, logic [7:0] d);
      regReq = '{1'b1, 1'b0, a, d};
      @(posedge mclk) #1;
      regReq.wrEn = 1'b0;
      @(posedge mclk) #1;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      regReq = '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk) #1;
      regReq.rdEn = 1'b0;
      // The valid flag stands for one cycle only, so it is looked at right here.
      cmp("rdValid", 8'h01, {7'h00, rdValid});
      cmp("rdData", e, rdData);
      @(posedge mclk) #1;
   endtask
   task automatic temp(logic signed [9:0] d, logic [7:0] e);
      tempSample = '{1'b1, d};
      @(posedge mclk) #1;
      tempSample.valid = 1'b0;
      @(posedge mclk) #1;
      rd(8'h00, e);
   endtask
   task automatic waitMode(logic v);
      for (int i = 0; i < 2000 && activeMode !== v; i++) @(posedge mclk) #1;
      cmp("activeMode", {7'h00, v}, {7'h00, activeMode});
      if (activeMode !== v) printVerdict();
   endtask
   task automatic printVerdict();
      if (nMismatch == 0 && totalChecks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      rst_n = 1'b0;
      regReq = '0;
      tempSample = '0;
      railPowerPins = 5'h0f;
      evIn = 3'h0;
      nMismatch = 0;
      totalChecks = 0;
      repeat (3) @(posedge mclk);
      #1 rst_n = 1'b1;
      foreach (ADR[i]) rd(ADR[i], DEF[i]);
      cmp("posTrim", 8'h23, posView);
      cmp("negTrim", 8'ha3, negView);
      cmp("biasCode", 8'h74, trims.biasLevelCode);
      // The source offset is left at its tracking code while the gate trim moves.
      wr(8'h02, 8'hcb);
      rd(8'h02, 8'h43);
      cmp("posTrim", 8'h43, posView);
      wr(8'h03, 8'h06);
      cmp("negTrim", 8'h06, negView);
      wr(8'h10, 8'h00);
      rd(8'h10, 8'h5a);
      rd(8'h3f, 8'h00);
      // The bias buffer waits for its pin even when its bit is set.
      wr(8'h01, 8'h30);
      @(posedge mclk) #1;
      cmp("rails", 8'h02, {6'h00, railCtl.systemSwitch, railCtl.biasBuffer});
      railPowerPins = 5'h1f;
      repeat (2) @(posedge mclk) #1;
      cmp("rails", 8'h03, {6'h00, railCtl.systemSwitch, railCtl.biasBuffer});
      wr(8'h0c, 8'h80);
      rd(8'h0c, 8'h80);
      cmp("convStart", 8'h01, {7'h00, convStart});
      temp(-10'sd20, 8'hf6);
      cmp("convStart", 8'h00, {7'h00, convStart});
      temp(10'sd100, 8'h55);
      temp(10'sd25, 8'h19);
      wr(8'h11, 8'h01);
      rd(8'h04, 8'h19);
      wr(8'h11, 8'h00);
      rd(8'h04, 8'h74);
      wr(8'h04, 8'hff);
      cmp("biasCode", 8'hff, trims.biasLevelCode);
      // The readings above raised hot, hot-escape and conversion-done events.
      rd(8'h07, 8'h18);
      cmp("eventPending", 8'h01, {7'h00, eventPending});
      rd(8'h08, 8'h01);
      cmp("eventPending", 8'h00, {7'h00, eventPending});
      evIn = 3'h7;
      @(posedge mclk) #1;
      evIn = 3'h0;
      @(posedge mclk) #1;
      cmp("eventPending", 8'h01, {7'h00, eventPending});
      wr(8'h05, 8'h00);
      cmp("eventPending", 8'h00, {7'h00, eventPending});
      rd(8'h07, 8'h64);
      // Power up, then drop the negative source while the positive bit stays set.
      wr(8'h01, 8'had);
      waitMode(1'b1);
      rd(8'h01, 8'h2d);
      cmp("sources", 8'h03, {6'h00, railCtl.posSource, railCtl.negSource});
      // The model never reports the negative source good, so its watch must expire.
      repeat (40) @(posedge mclk) #1;
      rd(8'h08, 8'h02);
      wr(8'h01, 8'h2c);
      @(posedge mclk) #1;
      cmp("sources", 8'h00, {6'h00, railCtl.posSource, railCtl.negSource});
      wr(8'h01, 8'hed);
      // Going down, the positive source leaves on an earlier strobe than the negative.
      for (int i = 0; i < 200 && railCtl.posSource; i++) @(posedge mclk) #1;
      cmp("sources", 8'h01, {6'h00, railCtl.posSource, railCtl.negSource});
      if (railCtl.posSource) printVerdict();
      waitMode(1'b0);
      rd(8'h01, 8'h2d);
      printVerdict();
   end
endmodule
